// file: interrupt_pending_capture.sv
// Behaviour
// - Two independent controllers, each with up to 63 request inputs.
// - Seven request levels per controller, nine source slots per level.
// - Every source of a controller gets its own distinct vector number.
// - 56 sources take software level 1-7 and priority; seven have fixed levels.
// - Each enabled clock, the 32 upper request lines are sampled into the high pending word.
// - Each enabled clock, lower request lines are sampled into low pending word bits 31-1.
// - Pending bits follow request lines even while masked.
// - The matching mask bit decides whether a pending source may request.
// - Pending bit 1 means request outstanding, 0 means none.
// - Mask bit 1 disables, 0 enables; reset sets every mask bit.
// - Writing mask bit 0 as one sets all 63 other mask bits.
`timescale 1ns/1ps

module interrupt_pending_capture #(
  parameter logic [pending_pkg::VEC_W-1:0] VECTOR_BASE_0 = 8'h40,
  parameter logic [pending_pkg::VEC_W-1:0] VECTOR_BASE_1 = 8'h80
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [pending_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pending_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pending_pkg::WORD_W-1:0] reg_rdata,
  // Source request lines, one map per controller
  input wire logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::MAP_W-1:0] src_req,
  // Requests to the core
  output logic [pending_pkg::NUM_CTRL-1:0] core_req,
  output logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::LEVEL_W-1:0] core_level,
  output logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::VEC_W-1:0] core_vector,
  // Event interrupt
  output logic irq
);
  import pending_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (int'(VECTOR_BASE_0) + MAP_W > 256 || int'(VECTOR_BASE_1) + MAP_W > 256) begin : g_vec_chk
    $error("vector base leaves no room for all sources");
  end
  if (NUM_PROG + (FIXED_LAST - FIXED_FIRST + 1) != NUM_SRC) begin : g_src_chk
    $error("programmable and fixed sources do not add up");
  end
  if (NUM_LEVELS * SLOTS_PER_LEVEL != NUM_SRC) begin : g_slot_chk
    $error("levels and slots do not cover the sources");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CTRL-1:0][MAP_W-1:0] pending;
    logic [NUM_CTRL-1:0][MAP_W-1:0] mask;
    logic [NUM_CTRL-1:0][MAP_W-1:0][CFG_W-1:0] cfg;
    logic [NUM_CTRL-1:0] req;
    logic [NUM_CTRL-1:0][LEVEL_W-1:0] level;
    logic [NUM_CTRL-1:0][VEC_W-1:0] vector;
    logic [NUM_CTRL-1:0][SRC_W-1:0] source;
    logic [NUM_CTRL-1:0] evt_status;
    logic [NUM_CTRL-1:0] evt_mask;
    logic [WORD_W-1:0] rdata;
  } state_t;

  state_t q;
  state_t d;

  // ----------------------------------------------------------------
  // Arbitration per controller
  // ----------------------------------------------------------------
  logic [NUM_CTRL-1:0] arb_found;
  logic [NUM_CTRL-1:0][LEVEL_W-1:0] arb_level;
  logic [NUM_CTRL-1:0][SRC_W-1:0] arb_source;
  logic [NUM_CTRL-1:0][VEC_W-1:0] vec_base;

  assign vec_base[0] = VECTOR_BASE_0;
  assign vec_base[1] = VECTOR_BASE_1;

  for (genvar c = 0; c < NUM_CTRL; c++) begin : g_ctrl
    // Masking gates only the request, never the captured pending bit
    level_arbiter u_arb (
      .req(q.pending[c] & ~q.mask[c]),
      .cfg(q.cfg[c]),
      .found(arb_found[c]),
      .level(arb_level[c]),
      .source(arb_source[c])
    );
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [1:0] sel;
  logic [7:0] off;
  logic cfg_area;
  logic [SRC_W-1:0] idx;
  logic is_global;

  assign sel = reg_addr[ADDR_W-1:CFG_AREA_BIT+1];
  assign off = reg_addr[7:0];
  assign cfg_area = reg_addr[CFG_AREA_BIT];
  assign idx = reg_addr[7:2];
  assign is_global = (sel == SEL_GLOBAL) && !cfg_area;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic ctrl_hit;
  logic [NUM_CTRL-1:0] evt_set;
  logic [NUM_CTRL-1:0] evt_clr;
  logic [CFG_W-1:0] cfg_rd;

  always_comb begin
    d = q;
    ctrl_hit = 1'b0;
    evt_set = '0;
    evt_clr = '0;
    cfg_rd = '0;
    if (clk_en) begin
      // Capture every enabled clock; bit 0 maps no source and stays clear
      for (int c = 0; c < NUM_CTRL; c++) begin
        d.pending[c][MAP_W-1:WORD_W] = src_req[c][MAP_W-1:WORD_W];
        d.pending[c][WORD_W-1:0] = src_req[c][WORD_W-1:0] & SRC_MAP_VALID[WORD_W-1:0];
      end

      // Register the winner; each source owns base plus index as vector
      for (int c = 0; c < NUM_CTRL; c++) begin
        d.req[c] = arb_found[c];
        d.level[c] = arb_level[c];
        d.source[c] = arb_source[c];
        d.vector[c] = vec_base[c] + {2'b00, arb_source[c]};
      end

      // Writes to controller registers; pending words ignore writes
      for (int c = 0; c < NUM_CTRL; c++) begin
        if (reg_wr && sel == 2'(c)) begin
          if (cfg_area) begin
            // Fixed-level sources and the empty slot 0 have no setting
            if (idx > SRC_W'(FIXED_LAST)) begin
              d.cfg[c][idx] = reg_wdata[CFG_W-1:0];
            end
          end else if (off == OFF_MASK_HI) begin
            d.mask[c][MAP_W-1:WORD_W] = reg_wdata;
          end else if (off == OFF_MASK_LO) begin
            if (reg_wdata[MASK_ALL_BIT]) begin
              d.mask[c] = MASK_RESET;
            end else begin
              d.mask[c][WORD_W-1:0] = reg_wdata;
            end
          end
          // OFF_PEND_HI and OFF_PEND_LO fall through untouched
        end
      end

      // Event flags: a new core request per controller; set beats clear
      if (reg_wr && is_global && off == OFF_EVT_STAT) begin
        evt_clr = reg_wdata[NUM_CTRL-1:0];
      end
      evt_set = arb_found & ~q.req;
      d.evt_status = (q.evt_status & ~evt_clr) | evt_set;
      if (reg_wr && is_global && off == OFF_EVT_MASK) begin
        d.evt_mask = reg_wdata[NUM_CTRL-1:0];
      end

      // Read data stands until the next enabled clock after the strobe
      d.rdata = '0;
      if (reg_rd) begin
        for (int c = 0; c < NUM_CTRL; c++) begin
          if (sel == 2'(c)) begin
            ctrl_hit = 1'b1;
            if (cfg_area) begin
              if (idx >= SRC_W'(FIXED_FIRST) && idx <= SRC_W'(FIXED_LAST)) begin
                cfg_rd = {idx[LEVEL_W-1:0], FIXED_PRIO};
              end else begin
                cfg_rd = q.cfg[c][idx];
              end
              d.rdata = {{(WORD_W-CFG_W){1'b0}}, cfg_rd};
            end else begin
              unique case (off)
                OFF_PEND_HI: d.rdata = q.pending[c][MAP_W-1:WORD_W];
                OFF_PEND_LO: d.rdata = q.pending[c][WORD_W-1:0];
                OFF_MASK_HI: d.rdata = q.mask[c][MAP_W-1:WORD_W];
                OFF_MASK_LO: d.rdata = q.mask[c][WORD_W-1:0];
                OFF_REQ_STAT: begin
                  d.rdata = {{(WORD_W-1-LEVEL_W-SRC_W){1'b0}},
                             q.req[c], q.level[c], q.source[c]};
                end
                default: d.rdata = '0;
              endcase
            end
          end
        end
        if (!ctrl_hit && is_global) begin
          unique case (off)
            OFF_EVT_STAT: d.rdata = {{(WORD_W-NUM_CTRL){1'b0}}, q.evt_status};
            OFF_EVT_MASK: d.rdata = {{(WORD_W-NUM_CTRL){1'b0}}, q.evt_mask};
            default: d.rdata = '0;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q.pending <= '0;
      q.mask <= {NUM_CTRL{MASK_RESET}};
      q.cfg <= {(NUM_CTRL*MAP_W){CFG_RESET}};
      q.req <= '0;
      q.level <= '0;
      q.vector <= '0;
      q.source <= '0;
      q.evt_status <= '0;
      q.evt_mask <= EVT_MASK_RESET;
      q.rdata <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = q.rdata;
  assign core_req = q.req;
  assign core_level = q.level;
  assign core_vector = q.vector;
  // Mask bit 1 disables the event, like the source masks
  assign irq = |(q.evt_status & ~q.evt_mask);

endmodule

// file: pending_pkg.sv
package pending_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_CTRL = 2;
  localparam int NUM_SRC = 63;
  localparam int MAP_W = 64;
  localparam int WORD_W = 32;
  localparam int SRC_W = 6;
  localparam int LEVEL_W = 3;
  localparam int PRIO_W = 3;
  localparam int CFG_W = LEVEL_W + PRIO_W;
  localparam int NUM_LEVELS = 7;
  localparam int SLOTS_PER_LEVEL = 9;
  localparam int NUM_PROG = 56;
  localparam int FIXED_FIRST = 1;
  localparam int FIXED_LAST = 7;
  localparam logic [PRIO_W-1:0] FIXED_PRIO = 3'h3;
  localparam int KEY_W = LEVEL_W + PRIO_W + 1;
  localparam int VEC_W = 8;
  localparam logic [MAP_W-1:0] SRC_MAP_VALID = 64'hFFFF_FFFF_FFFF_FFFE;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 11;
  localparam logic [1:0] SEL_GLOBAL = 2'h2;
  localparam logic [7:0] OFF_PEND_HI = 8'h00;
  localparam logic [7:0] OFF_PEND_LO = 8'h04;
  localparam logic [7:0] OFF_MASK_HI = 8'h08;
  localparam logic [7:0] OFF_MASK_LO = 8'h0C;
  localparam logic [7:0] OFF_REQ_STAT = 8'h10;
  localparam logic [7:0] OFF_EVT_STAT = 8'h00;
  localparam logic [7:0] OFF_EVT_MASK = 8'h04;
  localparam int CFG_AREA_BIT = 8;
  localparam int MASK_ALL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MAP_W-1:0] MASK_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [CFG_W-1:0] CFG_RESET = 6'h00;
  localparam logic [NUM_CTRL-1:0] EVT_MASK_RESET = 2'h3;

endpackage

`timescale 1ns/1ps

module level_arbiter (
  // Qualified requests and per-source level and priority
  input wire logic [pending_pkg::MAP_W-1:0] req,
  input wire logic [pending_pkg::MAP_W-1:0][pending_pkg::CFG_W-1:0] cfg,
  // Winner
  output logic found,
  output logic [pending_pkg::LEVEL_W-1:0] level,
  output logic [pending_pkg::SRC_W-1:0] source
);
  import pending_pkg::*;

  logic [KEY_W-1:0] best_key;
  logic [KEY_W-1:0] key;
  logic [LEVEL_W-1:0] lvl;

  // Fixed sources sit between priority 3 and 4 of their level, giving nine slots
  always_comb begin
    best_key = '0;
    key = '0;
    lvl = '0;
    found = 1'b0;
    level = '0;
    source = '0;
    for (int i = 1; i < MAP_W; i++) begin
      if (i >= FIXED_FIRST && i <= FIXED_LAST) begin
        lvl = LEVEL_W'(i);
        key = {lvl, FIXED_PRIO, 1'b1};
      end else begin
        lvl = cfg[i][CFG_W-1:PRIO_W];
        key = {cfg[i], 1'b0};
      end
      // Level 0 never reaches the core; on a tie the higher index wins
      if (req[i] && lvl != '0 && (!found || key >= best_key)) begin
        found = 1'b1;
        best_key = key;
        level = lvl;
        source = SRC_W'(i);
      end
    end
  end

endmodule

// file: interrupt_pending_capture_chk.sv
`timescale 1ns/1ps
module interrupt_pending_capture_chk import pending_pkg::*; #(
  parameter logic [7:0] VECTOR_BASE_0 = 8'h40
) (
  // Clock and control
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [pending_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pending_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pending_pkg::WORD_W-1:0] reg_rdata,
  // Sources and core side
  input wire logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::MAP_W-1:0] src_req,
  input wire logic [pending_pkg::NUM_CTRL-1:0] core_req,
  input wire logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::LEVEL_W-1:0] core_level,
  input wire logic [pending_pkg::NUM_CTRL-1:0][pending_pkg::VEC_W-1:0] core_vector,
  input wire logic irq
);
  import pending_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  pend_high_a: assert property (reg_rd && clk_en && reg_addr == 11'h000 && $stable(src_req)
    |=> reg_rdata == $past(src_req[0][63:32])) else $error("high pending word wrong");
  pend_low_a: assert property (reg_rd && clk_en && reg_addr == 11'h004 && $stable(src_req)
    |=> reg_rdata == ($past(src_req[0][31:0]) & SRC_MAP_VALID[31:0])) else $error("low word");
  mask_all_a: assert property (reg_wr && clk_en && reg_addr == 11'h00C && reg_wdata[0]
    ##1 reg_rd && reg_addr == 11'h008 |=> reg_rdata == 32'hFFFF_FFFF) else $error("mask all");
  mask_reset_a: assert property ($past(reset) && reg_rd && reg_addr == 11'h008
    |=> reg_rdata == 32'hFFFF_FFFF) else $error("mask reset value");
  req_cause_a: assert property (core_req[0] && $past(clk_en) && $past(clk_en, 2)
    |-> ($past(src_req[0], 2) & SRC_MAP_VALID) != 64'h0) else $error("request without source");
  req_level_a: assert property (core_req[0] == (core_level[0] != 3'h0))
    else $error("level and request disagree");
  vec_range_a: assert property (core_req[0] |-> core_vector[0] > VECTOR_BASE_0 &&
    core_vector[0] < VECTOR_BASE_0 + 8'h40) else $error("vector out of range");
  evt_masked_a: assert property (reg_wr && clk_en && reg_addr == 11'h404 &&
    reg_wdata[1:0] == 2'h3 |=> !irq) else $error("irq while events masked");
  cover property (core_req[0]);
  cover property (irq);
  cover property (reg_wr && reg_addr == 11'h00C);
  cover property (core_req[1]);
  cover property (!clk_en && core_req[0]);
endmodule
bind interrupt_pending_capture interrupt_pending_capture_chk #(
  .VECTOR_BASE_0(VECTOR_BASE_0)) chk_inst (.*);

// file: core_model.sv
`timescale 1ns/1ps
module core_model (
  // Clock
  input wire logic ref_clk,
  // Request from the controller
  input wire logic req,
  input wire logic [pending_pkg::VEC_W-1:0] vector,
  // Last vector taken
  output logic [pending_pkg::VEC_W-1:0] taken_q
);
  import pending_pkg::*;
  // The core only latches a vector while a request stands
  always_ff @(posedge ref_clk) begin
    if (req) begin
      taken_q <= vector;
    end
  end
endmodule

// file: interrupt_pending_capture_tb.sv
`timescale 1ns/1ps
module interrupt_pending_capture_tb;
  import pending_pkg::*;
  typedef struct {logic [63:0] src; logic [31:0] hi; logic [31:0] lo;} row_t;
  logic ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, clk_en = 1, irq;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata;
  logic [1:0][63:0] src_req = '0;
  logic [1:0] core_req;
  logic [1:0][2:0] core_level;
  logic [1:0][7:0] core_vector;
  logic [7:0] taken_q;
  int err_total = 0, total_checks = 0;
  row_t rows[4] = '{'{64'h8000_0000_0000_0001, 32'h8000_0000, 32'h0000_0000},
    '{64'h0123_4567_89AB_CDEF, 32'h0123_4567, 32'h89AB_CDEE},
    '{64'hFFFF_FFFF_FFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFE},
    '{64'h0000_0001_0000_0002, 32'h0000_0001, 32'h0000_0002}};
  always #12.5 ref_clk = ~ref_clk;
  interrupt_pending_capture interrupt_pending_capture_inst (.ref_clk(ref_clk), .reset(reset),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req), .core_req(core_req),
    .core_level(core_level), .core_vector(core_vector), .irq(irq));
  core_model core_model_inst (.ref_clk(ref_clk), .req(core_req[0]), .vector(core_vector[0]),
    .taken_q(taken_q));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [10:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask
  // Checks mid-cycle so the registered read data has settled
  task automatic rd(logic [10:0] a, logic [31:0] exp, string nm);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge ref_clk);
    reg_rd <= 0;
    @(negedge ref_clk);
    chk(nm, reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 0;
    rd(11'h008, 32'hFFFF_FFFF, "mask reset");
    // ----------------------------------------------------------------
    // Pending capture with every source masked
    // ----------------------------------------------------------------
    foreach (rows[i]) begin
      src_req <= {~rows[i].src, rows[i].src};
      repeat (2) @(posedge ref_clk);
      rd(11'h000, rows[i].hi, "pending high");
      rd(11'h004, rows[i].lo, "pending low");
      chk("masked req", {30'h0, core_req}, 32'h0);
    end
    $display("capture rows done");
    wr(11'h000, 32'h0000_0000);
    rd(11'h000, 32'h0000_0001, "pending write");
    rd(11'h01C, 32'h0000_0000, "unmapped");
    rd(11'h10C, 32'h0000_001B, "fixed cfg");
    // ----------------------------------------------------------------
    // Unmasked source 40 at level 5 reaches the core
    // ----------------------------------------------------------------
    // An edge between writes keeps the strobe from being driven twice in a step
    wr(11'h1A0, 32'h0000_0028);
    @(posedge ref_clk);
    wr(11'h008, 32'hFFFF_FEFF);
    @(posedge ref_clk);
    wr(11'h404, 32'h0000_0002);
    src_req <= {64'h0000_0100_0000_0000, 64'h0000_0100_0000_0000};
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("req", {30'h0, core_req}, 32'h0000_0001);
    chk("level", {29'h0, core_level[0]}, 32'h0000_0005);
    chk("vector", {24'h0, core_vector[0]}, 32'h0000_0068);
    chk("core took", {24'h0, taken_q}, 32'h0000_0068);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    @(posedge ref_clk);
    rd(11'h010, 32'h0000_0368, "req status");
    rd(11'h400, 32'h0000_0001, "event status");
    wr(11'h400, 32'h0000_0001);
    @(negedge ref_clk);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    $display("request path done");
    // ----------------------------------------------------------------
    // Clock enable low freezes the request although the source drops
    // ----------------------------------------------------------------
    @(posedge ref_clk);
    clk_en <= 0;
    src_req <= '0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("frozen req", {30'h0, core_req}, 32'h0000_0001);
    @(posedge ref_clk);
    clk_en <= 1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("thawed req", {30'h0, core_req}, 32'h0000_0000);
    $display("clock enable done");
    // ----------------------------------------------------------------
    // Second controller, source 40 at level 7
    // ----------------------------------------------------------------
    @(posedge ref_clk);
    src_req <= {64'h0000_0100_0000_0000, 64'h0000_0100_0000_0000};
    wr(11'h3A0, 32'h0000_0038);
    @(posedge ref_clk);
    wr(11'h208, 32'hFFFF_FEFF);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("both req", {30'h0, core_req}, 32'h0000_0003);
    chk("level 1", {29'h0, core_level[1]}, 32'h0000_0007);
    chk("vector 1", {24'h0, core_vector[1]}, 32'h0000_00A8);
    chk("irq again", {31'h0, irq}, 32'h0000_0001);
    $display("second controller done");
    // ----------------------------------------------------------------
    // Mask-all on both controllers, then events masked
    // ----------------------------------------------------------------
    @(posedge ref_clk);
    wr(11'h20C, 32'h0000_0001);
    @(posedge ref_clk);
    wr(11'h00C, 32'h0000_0001);
    rd(11'h008, 32'hFFFF_FFFF, "mask all");
    rd(11'h208, 32'hFFFF_FFFF, "mask all 1");
    @(negedge ref_clk);
    chk("req off", {30'h0, core_req}, 32'h0000_0000);
    @(posedge ref_clk);
    wr(11'h404, 32'h0000_0003);
    @(negedge ref_clk);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    $display("mask all done");
    // ----------------------------------------------------------------
    // Reset in mid-run restores the masks
    // ----------------------------------------------------------------
    @(posedge ref_clk);
    wr(11'h008, 32'hFFFF_FEFF);
    reset <= 1;
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    rd(11'h008, 32'hFFFF_FFFF, "mask after reset");
    @(negedge ref_clk);
    chk("req after reset", {30'h0, core_req}, 32'h0000_0000);
    chk("irq after reset", {31'h0, irq}, 32'h0000_0000);
    $display("reset done");
    wrap_up();
  end
endmodule
